//--- acg_pkg.sv
// Shared constants for the audio converter clock generator of one partition.
// Assumes every user includes this file first and names items as acg_pkg::name.
package acg_pkg;

	// ==========================================================================
	// Register map.
	localparam logic [7:0] REG_CLK_SRC_SEL_ADDR = 8'h66;
	localparam logic [7:0] REG_CLK_SRC_SEL_RESET = 8'h00;
	localparam int DIV_SRC_MSB = 7;
	localparam int DIV_SRC_LSB = 6;
	localparam int LOOP_SRC_MSB = 5;
	localparam int LOOP_SRC_LSB = 4;
	localparam logic [7:0] REG_CLK_SRC_SEL_MASK = 8'hF0;

	// ==========================================================================
	// Source selector encodings.
	localparam logic [1:0] SRC_MASTER_CLOCK = 2'h0;
	localparam logic [1:0] SRC_BIT_CLOCK = 2'h1;
	localparam logic [1:0] SRC_AUX_PIN_TWO = 2'h2;

	// ==========================================================================
	// Divider and loop figures.
	localparam int REF_PER_MASTER = 256;
	localparam int DIV_REF_FACTOR = 128;
	localparam int LOOP_REF_FACTOR = 2048;
	localparam int LOOP_PER_MASTER = LOOP_REF_FACTOR / REF_PER_MASTER;
	localparam int FRAC_SCALE = 10000;
	localparam int FRAC_MAX = 9999;
	localparam int BASE_DIV_MIN = 2;
	localparam int BASE_DIV_MAX = 17;
	localparam int FRONT_DIV_MIN = 1;
	localparam int FRONT_DIV_MAX = 8;
	localparam int LOOP_GAIN_MIN = 1;
	localparam int LOOP_GAIN_MAX = 16;
	localparam int WHOLE_MULT_MIN = 1;
	localparam int WHOLE_MULT_MAX = 63;
	localparam int OUT_DIV_B_MIN = 2;
	localparam int OUT_DIV_B_MAX = 17;
	localparam int OUT_STEP_DIRECT = 2;
	localparam int OUT_STEP_LOOP = 4;

	// ==========================================================================
	// Rate divider, counted in half steps (2 means a ratio of 1, 12 means 6).
	localparam int RATE_HALF_MIN = 2;
	localparam int RATE_HALF_MAX = 12;
	localparam int RATE_HALF_FACTOR = REF_PER_MASTER / 2;
	localparam int RATE_PERIOD_W = 11;

endpackage

//--- acg_pin_sync.sv
// Two-flop synchroniser with registered edge pulses for one external clock pin.
// Assumes the pin is asynchronous to i_clk_sys and toggles well below half its rate.
`timescale 1ns/1ps
`default_nettype none

module acg_pin_sync (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Pin and decoded edges.
	input wire logic i_pin,
	output logic o_rise,
	output logic o_fall
);

	logic meta_ff;
	logic sync_ff;
	logic last_ff;
	logic rise_ff;
	logic fall_ff;
	logic nxt_rise;
	logic nxt_fall;

	// ==========================================================================
	// Edge decode looks only at the second and third stages, never the first.
	always_comb begin
		nxt_rise = sync_ff & ~last_ff;
		nxt_fall = ~sync_ff & last_ff;
	end

	// Registering stages; the first flop feeds nothing but the second.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			meta_ff <= i_pin;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
			rise_ff <= nxt_rise;
			fall_ff <= nxt_fall;
		end
	end

	assign o_rise = rise_ff;
	assign o_fall = fall_ff;

endmodule

`default_nettype wire

//--- acg_rate_div.sv
// Converter sample-rate divider: turns master-clock ticks into sample ticks.
// Assumes i_tick is a one-cycle enable at 256 times the reference rate.
`timescale 1ns/1ps
`default_nettype none

module acg_rate_div (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Configuration.
	input wire logic [3:0] i_half_steps,
	input wire logic i_double,
	// Timing.
	input wire logic i_run,
	input wire logic i_tick,
	output logic o_sample,
	output logic [acg_pkg::RATE_PERIOD_W-1:0] o_period
);

	localparam int W = acg_pkg::RATE_PERIOD_W;

	logic [W-1:0] cnt_ff;
	logic sample_ff;
	logic [W-1:0] period_ff;
	logic [W-1:0] nxt_cnt;
	logic nxt_sample;
	logic [W-1:0] nxt_period;
	logic [3:0] half_eff;
	logic [W-1:0] full;

	// ==========================================================================
	// Period is 128 master ticks per half step, halved in double-rate mode.
	// Out-of-range settings clamp, so a bad write never stalls the counter.
	always_comb begin
		half_eff = i_half_steps;
		if (half_eff < 4'(acg_pkg::RATE_HALF_MIN)) begin
			half_eff = 4'(acg_pkg::RATE_HALF_MIN);
		end
		if (half_eff > 4'(acg_pkg::RATE_HALF_MAX)) begin
			half_eff = 4'(acg_pkg::RATE_HALF_MAX);
		end
		full = W'(half_eff) * W'(acg_pkg::RATE_HALF_FACTOR);
		nxt_period = i_double ? (full >> 1) : full; // [R3] [R19]
		nxt_cnt = cnt_ff;
		nxt_sample = 1'b0;
		if (!i_run) begin
			nxt_cnt = '0;
		end else if (i_tick) begin
			if (cnt_ff >= period_ff - W'(1)) begin
				nxt_cnt = '0;
				nxt_sample = 1'b1; // [R1]
			end else begin
				nxt_cnt = cnt_ff + W'(1);
			end
		end
	end

	// State registers.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			cnt_ff <= '0;
			sample_ff <= 1'b0;
			period_ff <= W'(acg_pkg::RATE_HALF_MIN * acg_pkg::RATE_HALF_FACTOR);
		end else begin
			cnt_ff <= nxt_cnt;
			sample_ff <= nxt_sample;
			period_ff <= nxt_period;
		end
	end

	assign o_sample = sample_ff;
	assign o_period = period_ff;

endmodule

`default_nettype wire

//--- acg_clock_gen.sv
// Clock generation for one converter partition: source muxes, integer divider,
// fractional loop, converter rate dividers, word clocks and auxiliary clock out.
// Assumes all external clocks are far slower than i_clk_sys; every derived clock
// except the toggled aux clock out is a one-cycle enable on i_clk_sys, and pin clocks toggle at most once a cycle.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) Sample rates 8 to 96 kHz, partitions asynchronous.
// (R2) Each partition has identical independent clock logic.
// (R3) DAC rate is reference over divider, optionally doubled.
// (R4) One reference rate, separate ADC and DAC dividers.
// (R5) Split rates: word pin DAC, aux one ADC.
// (R6) Converter master clock is 256 times reference.
// (R7) Master input feeds integer divider or loop.
// (R8) Divider mode: reference is source over 128 times base.
// (R9) Divider source chosen by register bits seven-six.
// (R10) Half-step divider needs even base, 39-53 kHz.
// (R11) Loop mode: source times ratio gain over 2048 front.
// (R12) Loop ratio is whole part plus four-digit fraction.
// (R13) Loop source chosen by register bits five-four.
// (R14) Loop input and output ranges kept by configurer.
// (R15) Loop keeps running and drives aux one when powered down.
// (R16) Loop clock out: two source ratio gain over divisors.
// (R17) Direct clock out: twice divider source over divisors.
// (R18) Shared word clock follows the faster converter rate.
// (R19) ADC divider mirrors DAC divider, applied independently.
// (R20) Loop output scaled to exactly 256 times reference.
module acg_clock_gen (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// External clock pins.
	input wire logic i_master_clock_in,
	input wire logic i_bit_clock_pin,
	input wire logic i_aux_pin_two,
	// Register port.
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Loop and divider configuration.
	input wire logic i_loop_en,
	input wire logic [3:0] i_front_div,
	input wire logic [4:0] i_loop_gain,
	input wire logic [5:0] i_whole_mult,
	input wire logic [13:0] i_frac_part,
	input wire logic [4:0] i_base_div,
	// Clock output configuration.
	input wire logic i_clock_out_select,
	input wire logic i_clock_out_en,
	input wire logic [1:0] i_out_div_a_sel,
	input wire logic [4:0] i_out_div_b,
	// Converter rate configuration.
	input wire logic [3:0] i_dac_rate_divider,
	input wire logic i_dac_double_rate,
	input wire logic [3:0] i_adc_rate_divider,
	input wire logic i_adc_double_rate,
	input wire logic i_split_word_clock,
	input wire logic i_codec_power_down,
	// Pins driven by the block.
	output logic o_aux_pin_one,
	output logic o_aux_pin_one_oe,
	output logic o_word_clock_pin,
	// Converter timing and status.
	output logic o_master_tick,
	output logic o_ref_tick,
	output logic o_dac_sample,
	output logic o_adc_sample,
	output logic o_loop_active
);

	localparam int POOL_W = 32;
	localparam int ACC_W = 9;
	localparam logic [POOL_W-1:0] POOL_SCALE = POOL_W'(acg_pkg::FRAC_SCALE);

	// ==========================================================================
	// Pin synchronisers.
	logic mclk_rise, mclk_fall, bclk_rise, bclk_fall, aux2_rise, aux2_fall;

	acg_pin_sync u_sync_mclk (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_pin(i_master_clock_in),
		.o_rise(mclk_rise),
		.o_fall(mclk_fall)
	);

	acg_pin_sync u_sync_bclk (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_pin(i_bit_clock_pin),
		.o_rise(bclk_rise),
		.o_fall(bclk_fall)
	);

	acg_pin_sync u_sync_aux2 (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_pin(i_aux_pin_two),
		.o_rise(aux2_rise),
		.o_fall(aux2_fall)
	);

	// ==========================================================================
	// Register file.
	logic [7:0] src_sel_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_src_sel;
	logic [7:0] nxt_rdata;

	// Only the two selector fields are stored; the low nibble reads as zero.
	always_comb begin
		nxt_src_sel = src_sel_ff;
		if (i_reg_wr && i_reg_addr == acg_pkg::REG_CLK_SRC_SEL_ADDR) begin
			nxt_src_sel = i_reg_wdata & acg_pkg::REG_CLK_SRC_SEL_MASK;
		end
		nxt_rdata = (i_reg_addr == acg_pkg::REG_CLK_SRC_SEL_ADDR) ? src_sel_ff : 8'h00;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			src_sel_ff <= acg_pkg::REG_CLK_SRC_SEL_RESET;
			rdata_ff <= 8'h00;
		end else begin
			src_sel_ff <= nxt_src_sel;
			rdata_ff <= nxt_rdata;
		end
	end

	// ==========================================================================
	// Source selection and setting clamps.
	logic [1:0] div_src;
	logic [1:0] loop_src;
	logic div_edge;
	logic loop_rise;
	logic [4:0] q_eff;
	logic [3:0] p_eff;
	logic [4:0] r_eff;
	logic [5:0] j_eff;
	logic [13:0] d_eff;
	logic [4:0] n_eff;
	logic [ACC_W-1:0] mn;
	logic [POOL_W-1:0] loop_inc;

	// Divider source counts both edges so odd base values stay exact.
	always_comb begin
		div_src = src_sel_ff[acg_pkg::DIV_SRC_MSB:acg_pkg::DIV_SRC_LSB];
		loop_src = src_sel_ff[acg_pkg::LOOP_SRC_MSB:acg_pkg::LOOP_SRC_LSB];
		unique case (div_src) // [R9]
			acg_pkg::SRC_BIT_CLOCK: div_edge = bclk_rise | bclk_fall;
			acg_pkg::SRC_AUX_PIN_TWO: div_edge = aux2_rise | aux2_fall;
			default: div_edge = mclk_rise | mclk_fall;
		endcase
		unique case (loop_src) // [R13]
			acg_pkg::SRC_BIT_CLOCK: loop_rise = bclk_rise;
			acg_pkg::SRC_AUX_PIN_TWO: loop_rise = aux2_rise; // [R15]
			default: loop_rise = mclk_rise;
		endcase
		q_eff = i_base_div;
		if (q_eff < 5'(acg_pkg::BASE_DIV_MIN)) q_eff = 5'(acg_pkg::BASE_DIV_MIN);
		if (q_eff > 5'(acg_pkg::BASE_DIV_MAX)) q_eff = 5'(acg_pkg::BASE_DIV_MAX);
		p_eff = i_front_div;
		if (p_eff < 4'(acg_pkg::FRONT_DIV_MIN)) p_eff = 4'(acg_pkg::FRONT_DIV_MIN);
		if (p_eff > 4'(acg_pkg::FRONT_DIV_MAX)) p_eff = 4'(acg_pkg::FRONT_DIV_MAX);
		r_eff = i_loop_gain;
		if (r_eff < 5'(acg_pkg::LOOP_GAIN_MIN)) r_eff = 5'(acg_pkg::LOOP_GAIN_MIN);
		if (r_eff > 5'(acg_pkg::LOOP_GAIN_MAX)) r_eff = 5'(acg_pkg::LOOP_GAIN_MAX);
		j_eff = i_whole_mult;
		if (j_eff < 6'(acg_pkg::WHOLE_MULT_MIN)) j_eff = 6'(acg_pkg::WHOLE_MULT_MIN);
		d_eff = i_frac_part;
		if (d_eff > 14'(acg_pkg::FRAC_MAX)) d_eff = 14'(acg_pkg::FRAC_MAX);
		n_eff = i_out_div_b;
		if (n_eff < 5'(acg_pkg::OUT_DIV_B_MIN)) n_eff = 5'(acg_pkg::OUT_DIV_B_MIN);
		if (n_eff > 5'(acg_pkg::OUT_DIV_B_MAX)) n_eff = 5'(acg_pkg::OUT_DIV_B_MAX);
		mn = ACC_W'(n_eff) << i_out_div_a_sel; // [R17]
		// Ratio in units of 1/10000, times the loop gain.
		loop_inc = (POOL_W'(j_eff) * POOL_SCALE + POOL_W'(d_eff)) * POOL_W'(r_eff); // [R12]
	end

	// ==========================================================================
	// Loop, integer divider, reference counter and clock-out divider; one set per partition. [R2]
	logic [3:0] pre_cnt_ff, nxt_pre_cnt;
	logic [POOL_W-1:0] pool_ff, nxt_pool;
	logic [2:0] loop_cnt_ff, nxt_loop_cnt;
	logic [4:0] int_cnt_ff, nxt_int_cnt;
	logic [7:0] ref_cnt_ff, nxt_ref_cnt;
	logic mtick_ff, nxt_mtick;
	logic rtick_ff, nxt_rtick;
	logic [ACC_W-1:0] od_acc_ff, nxt_od_acc;
	logic out_clk_ff, nxt_out_clk;
	logic loop_act_ff, nxt_loop_act;
	logic pre_edge;
	logic loop_tick;
	logic [ACC_W-1:0] od_step;
	logic [ACC_W-1:0] od_sum;

	// The loop is modelled as a credit pool: each front-divided source edge adds
	// the scaled ratio, and one loop tick drains per cycle. Average rate is exact,
	// but a loop output above the system clock rate cannot be represented.
	always_comb begin
		nxt_pre_cnt = pre_cnt_ff;
		pre_edge = 1'b0;
		if (!i_loop_en) begin
			nxt_pre_cnt = '0;
		end else if (loop_rise) begin
			if (pre_cnt_ff >= p_eff - 4'(1)) begin
				nxt_pre_cnt = '0;
				pre_edge = 1'b1; // [R11]
			end else begin
				nxt_pre_cnt = pre_cnt_ff + 4'(1);
			end
		end
		loop_tick = i_loop_en && (pool_ff >= POOL_SCALE);
		nxt_pool = pool_ff + (pre_edge ? loop_inc : '0) - (loop_tick ? POOL_SCALE : '0);
		if (!i_loop_en) begin
			nxt_pool = '0;
		end
		nxt_loop_cnt = loop_tick ? loop_cnt_ff + 3'(1) : loop_cnt_ff;
		if (!i_loop_en) begin
			nxt_loop_cnt = '0;
		end
		// Integer path: 256Q source edges per 256 master ticks means one every Q.
		nxt_int_cnt = int_cnt_ff;
		nxt_mtick = 1'b0;
		if (i_loop_en) begin
			nxt_int_cnt = '0;
			// Eight loop ticks per master tick gives exactly 256 per reference.
			nxt_mtick = loop_tick && (loop_cnt_ff == 3'(acg_pkg::LOOP_PER_MASTER - 1)); // [R20] [R7]
		end else if (div_edge) begin
			if (int_cnt_ff >= q_eff - 5'(1)) begin
				nxt_int_cnt = '0;
				nxt_mtick = 1'b1; // [R8] [R7]
			end else begin
				nxt_int_cnt = int_cnt_ff + 5'(1);
			end
		end
		// Converter timing stops when powered down; the loop carries on.
		if (i_codec_power_down) begin
			nxt_mtick = 1'b0; // [R15]
		end
		nxt_ref_cnt = ref_cnt_ff;
		nxt_rtick = 1'b0;
		if (i_codec_power_down) begin
			nxt_ref_cnt = '0;
		end else if (mtick_ff) begin
			nxt_ref_cnt = ref_cnt_ff + 8'(1); // [R6]
			nxt_rtick = (ref_cnt_ff == 8'(acg_pkg::REF_PER_MASTER - 1));
		end
		// Clock-out divider: toggles at step/(M*N) of its input tick rate.
		if (i_clock_out_select) begin
			od_step = div_edge ? ACC_W'(acg_pkg::OUT_STEP_DIRECT) : '0; // [R17]
		end else begin
			od_step = loop_tick ? ACC_W'(acg_pkg::OUT_STEP_LOOP) : '0; // [R16]
		end
		od_sum = od_acc_ff + od_step;
		nxt_od_acc = od_sum;
		nxt_out_clk = out_clk_ff;
		if (!i_clock_out_select && !i_loop_en) begin
			nxt_od_acc = '0;
			nxt_out_clk = 1'b0;
		end else if (od_sum >= mn) begin
			nxt_od_acc = od_sum - mn;
			nxt_out_clk = ~out_clk_ff;
		end
		nxt_loop_act = i_loop_en;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			pre_cnt_ff <= '0;
			pool_ff <= '0;
			loop_cnt_ff <= '0;
			int_cnt_ff <= '0;
			ref_cnt_ff <= '0;
			mtick_ff <= 1'b0;
			rtick_ff <= 1'b0;
			od_acc_ff <= '0;
			out_clk_ff <= 1'b0;
			loop_act_ff <= 1'b0;
		end else begin
			pre_cnt_ff <= nxt_pre_cnt;
			pool_ff <= nxt_pool;
			loop_cnt_ff <= nxt_loop_cnt;
			int_cnt_ff <= nxt_int_cnt;
			ref_cnt_ff <= nxt_ref_cnt;
			mtick_ff <= nxt_mtick;
			rtick_ff <= nxt_rtick;
			od_acc_ff <= nxt_od_acc;
			out_clk_ff <= nxt_out_clk;
			loop_act_ff <= nxt_loop_act;
		end
	end

	// ==========================================================================
	// Converter rate dividers share one master tick but count independently.
	logic dac_sample, adc_sample;
	logic [acg_pkg::RATE_PERIOD_W-1:0] dac_period, adc_period;

	acg_rate_div u_dac_div (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_half_steps(i_dac_rate_divider),
		.i_double(i_dac_double_rate),
		.i_run(~i_codec_power_down),
		.i_tick(mtick_ff), // [R4]
		.o_sample(dac_sample),
		.o_period(dac_period)
	);

	acg_rate_div u_adc_div (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_half_steps(i_adc_rate_divider),
		.i_double(i_adc_double_rate),
		.i_run(~i_codec_power_down),
		.i_tick(mtick_ff), // [R4] [R19]
		.o_sample(adc_sample),
		.o_period(adc_period)
	);

	// ==========================================================================
	// Pin outputs.
	logic wclk_ff, nxt_wclk;
	logic aux1_ff, nxt_aux1;
	logic aux1_oe_ff, nxt_aux1_oe;
	logic dac_s_ff, adc_s_ff;

	// Shared word clock follows the shorter period; in split mode the word pin
	// carries DAC frames and aux one carries ADC frames on the same bit clock.
	always_comb begin
		if (i_split_word_clock) begin
			nxt_wclk = dac_sample; // [R5]
			nxt_aux1 = adc_sample; // [R5]
			nxt_aux1_oe = 1'b1;
		end else begin
			nxt_wclk = (adc_period < dac_period) ? adc_sample : dac_sample; // [R18]
			nxt_aux1 = i_clock_out_en & out_clk_ff; // [R15] [R16] [R17]
			nxt_aux1_oe = i_clock_out_en;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			wclk_ff <= 1'b0;
			aux1_ff <= 1'b0;
			aux1_oe_ff <= 1'b0;
			dac_s_ff <= 1'b0;
			adc_s_ff <= 1'b0;
		end else begin
			wclk_ff <= nxt_wclk;
			aux1_ff <= nxt_aux1;
			aux1_oe_ff <= nxt_aux1_oe;
			dac_s_ff <= dac_sample;
			adc_s_ff <= adc_sample;
		end
	end

	assign o_reg_rdata = rdata_ff;
	assign o_aux_pin_one = aux1_ff;
	assign o_aux_pin_one_oe = aux1_oe_ff;
	assign o_word_clock_pin = wclk_ff;
	assign o_master_tick = mtick_ff;
	assign o_ref_tick = rtick_ff;
	assign o_dac_sample = dac_s_ff;
	assign o_adc_sample = adc_s_ff;
	assign o_loop_active = loop_act_ff;

endmodule

`default_nettype wire

//--- acg_monitor.sv
// Port-level checker for the one-partition clock generator.
// Assumes a single i_clk_sys domain; bound onto acg_clock_gen below.
`timescale 1ns/1ps
`default_nettype none

module acg_monitor (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Register port.
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	// Mode inputs.
	input wire logic i_split_word_clock,
	input wire logic i_clock_out_en,
	input wire logic i_codec_power_down,
	// Watched outputs.
	input wire logic o_aux_pin_one,
	input wire logic o_aux_pin_one_oe,
	input wire logic o_word_clock_pin,
	input wire logic o_master_tick,
	input wire logic o_ref_tick,
	input wire logic o_dac_sample,
	input wire logic o_adc_sample
);
	default clocking mon_cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);

	// ============================
	// Master ticks since the last reference tick, cleared in power down.
	logic [9:0] mt_cnt_ff;
	logic [9:0] nxt_mt_cnt;
	always_comb begin
		nxt_mt_cnt = mt_cnt_ff;
		if (i_codec_power_down || o_ref_tick) nxt_mt_cnt = 10'h000;
		if (o_master_tick && !i_codec_power_down) nxt_mt_cnt = nxt_mt_cnt + 10'h001;
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) mt_cnt_ff <= 10'h000;
		else mt_cnt_ff <= nxt_mt_cnt;
	end

	// ============================
	// Properties.
	sequence s_wr_sel;
		i_reg_wr && i_reg_addr == 8'h66;
	endsequence
	sequence s_hold_sel;
		!i_reg_wr && i_reg_addr == 8'h66;
	endsequence
	property p_wr_visible;
		s_wr_sel ##1 s_hold_sel |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'hF0);
	endproperty
	property p_unmapped;
		i_reg_addr != 8'h66 |=> o_reg_rdata == 8'h00;
	endproperty
	property p_low_nibble;
		o_reg_rdata[3:0] == 4'h0;
	endproperty
	property p_tick_pulse;
		o_master_tick |=> !o_master_tick;
	endproperty
	property p_ref_count;
		disable iff (i_srst || i_codec_power_down) o_ref_tick |-> mt_cnt_ff == 10'h100;
	endproperty
	property p_pd_quiet;
		i_codec_power_down [*4] |-> !o_master_tick && !o_ref_tick && !o_dac_sample && !o_adc_sample;
	endproperty
	property p_split_word;
		i_split_word_clock && o_dac_sample |-> ##[0:2] o_word_clock_pin;
	endproperty
	property p_split_adc;
		i_split_word_clock && o_adc_sample |-> ##[0:2] o_aux_pin_one;
	endproperty
	property p_split_oe;
		i_split_word_clock [*3] |-> o_aux_pin_one_oe;
	endproperty
	property p_oe_idle;
		(!i_split_word_clock && !i_clock_out_en) [*3] |-> !o_aux_pin_one_oe;
	endproperty

	a_wr_visible: assert property (p_wr_visible)
		else $error("register write not read back");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address read nonzero");
	a_low_nibble: assert property (p_low_nibble)
		else $error("unused register bits read nonzero");
	a_tick_pulse: assert property (p_tick_pulse)
		else $error("master tick longer than one cycle");
	a_ref_count: assert property (p_ref_count)
		else $error("reference tick not after 256 master ticks");
	a_pd_quiet: assert property (p_pd_quiet)
		else $error("converter timing runs in power down");
	a_split_word: assert property (p_split_word)
		else $error("word pin missed a DAC frame");
	a_split_adc: assert property (p_split_adc)
		else $error("aux pin missed an ADC frame");
	a_split_oe: assert property (p_split_oe)
		else $error("aux pin not driven in split mode");
	a_oe_idle: assert property (p_oe_idle)
		else $error("aux pin driven while unused");
endmodule

bind acg_clock_gen acg_monitor u_mon (.i_clk_sys, .i_srst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
	.o_reg_rdata, .i_split_word_clock, .i_clock_out_en, .i_codec_power_down, .o_aux_pin_one,
	.o_aux_pin_one_oe, .o_word_clock_pin, .o_master_tick, .o_ref_tick, .o_dac_sample, .o_adc_sample);

`default_nettype wire

//--- acg_clk_src.sv
// External clock sources feeding the partition's clock pins.
// Assumes a 5 ns system clock; half periods are whole multiples of it.
`timescale 1ns/1ps
`default_nettype none

module acg_clk_src (
	// Clock pins toward the block.
	output logic o_master_clock_in,
	output logic o_bit_clock_pin,
	output logic o_aux_pin_two
);
	// ============================
	// Free-running sources; odd offsets keep edges off the system clock edge.
	initial begin
		o_master_clock_in = 1'b0;
		#1.3;
		forever #20 o_master_clock_in = ~o_master_clock_in;
	end
	initial begin
		o_bit_clock_pin = 1'b0;
		#2.1;
		forever #25 o_bit_clock_pin = ~o_bit_clock_pin;
	end
	initial begin
		o_aux_pin_two = 1'b0;
		#3.7;
		forever #30 o_aux_pin_two = ~o_aux_pin_two;
	end
endmodule

`default_nettype wire

//--- tb_acg_clock_gen.sv
// Self-checking bench for the one-partition clock generator.
// Assumes the package, clock source model and checker compile first.
`timescale 1ns/1ps
`default_nettype none

module tb_acg_clock_gen;
	// ============================
	// Design inputs, all valued at time zero.
	logic i_clk_sys;
	logic i_srst = 1'b1;
	logic [7:0] i_reg_addr = 8'h00;
	logic i_reg_wr = 1'b0;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_loop_en = 1'b0;
	logic [3:0] i_front_div = 4'h1;
	logic [4:0] i_loop_gain = 5'h01;
	logic [5:0] i_whole_mult = 6'h08;
	logic [13:0] i_frac_part = 14'h0000;
	logic [4:0] i_base_div = 5'h02;
	logic i_clock_out_select = 1'b0;
	logic i_clock_out_en = 1'b0;
	logic [1:0] i_out_div_a_sel = 2'h0;
	logic [4:0] i_out_div_b = 5'h02;
	logic [3:0] i_dac_rate_divider = 4'h2;
	logic i_dac_double_rate = 1'b0;
	logic [3:0] i_adc_rate_divider = 4'h2;
	logic i_adc_double_rate = 1'b0;
	logic i_split_word_clock = 1'b0;
	logic i_codec_power_down = 1'b0;
	wire logic i_master_clock_in, i_bit_clock_pin, i_aux_pin_two;
	// Design outputs.
	logic [7:0] o_reg_rdata;
	logic o_aux_pin_one, o_aux_pin_one_oe, o_word_clock_pin, o_master_tick, o_ref_tick;
	logic o_dac_sample, o_adc_sample, o_loop_active;
	// Bench state.
	logic aux_q;
	logic [5:0] ev;
	int failures = 0;
	int num_checks = 0;
	int c;
	int dq[5] = '{2, 2, 2, 2, 17};
	int dh[5] = '{4, 5, 6, 4, 4};
	int lt[6][7] = '{'{8, 0, 1, 2, 0, 48, 3}, '{7, 5000, 1, 2, 0, 256, 15}, '{4, 0, 2, 2, 0, 48, 3},
		'{16, 0, 1, 4, 0, 32, 2}, '{4, 5000, 1, 1, 1, 160, 9}, '{6, 0, 1, 1, 2, 48, 3}};
	int ct[5][5] = '{'{1, 0, 0, 2, 8}, '{1, 0, 1, 3, 24}, '{1, 1, 3, 17, 544}, '{0, 1, 2, 4, 16},
		'{0, 1, 3, 17, 136}};

	acg_clk_src u_src (.o_master_clock_in(i_master_clock_in), .o_bit_clock_pin(i_bit_clock_pin),
		.o_aux_pin_two(i_aux_pin_two));
	acg_clock_gen dut (.i_clk_sys, .i_srst, .i_master_clock_in, .i_bit_clock_pin, .i_aux_pin_two,
		.i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_loop_en, .i_front_div, .i_loop_gain,
		.i_whole_mult, .i_frac_part, .i_base_div, .i_clock_out_select, .i_clock_out_en,
		.i_out_div_a_sel, .i_out_div_b, .i_dac_rate_divider, .i_dac_double_rate, .i_adc_rate_divider,
		.i_adc_double_rate, .i_split_word_clock, .i_codec_power_down, .o_aux_pin_one,
		.o_aux_pin_one_oe, .o_word_clock_pin, .o_master_tick, .o_ref_tick, .o_dac_sample,
		.o_adc_sample, .o_loop_active);

	// ============================
	// Clock and event taps; source periods are whole cycles, so spans are exact.
	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) aux_q <= o_aux_pin_one;
	assign ev = {o_aux_pin_one & ~aux_q, o_word_clock_pin, o_adc_sample, o_dac_sample, o_ref_tick, o_master_tick};

	// ============================
	// Tasks.
	task automatic tick();
		@(posedge i_clk_sys);
		#1;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		tick();
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		tick();
		i_reg_wr = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		tick();
		i_reg_addr = a;
		repeat (2) @(posedge i_clk_sys);
		#1 d = o_reg_rdata;
	endtask
	// Lets a new setting settle, then times n periods of event w.
	task automatic meas(input string what, input int w, input int n, input int exp);
		int hits;
		int cyc;
		repeat (100) @(posedge i_clk_sys);
		hits = -1;
		cyc = 0;
		for (int g = 0; g < 60000 && hits < n; g++) begin
			tick();
			if (hits >= 0) cyc++;
			if (ev[w] === 1'b1) hits++;
		end
		check(what, cyc, exp);
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ============================
	// Main sequence.
	initial begin
		logic [7:0] rd;
		repeat (10) @(posedge i_clk_sys);
		#1 i_srst = 1'b0;
		reg_rd(8'h66, rd);
		check("reg reset", rd, acg_pkg::REG_CLK_SRC_SEL_RESET);
		reg_wr(8'h66, 8'hFF);
		reg_rd(8'h66, rd);
		check("reg bits", rd, acg_pkg::REG_CLK_SRC_SEL_MASK);
		reg_wr(8'h10, 8'h00);
		reg_rd(8'h10, rd);
		check("reg unmapped", rd, 8'h00);
		reg_rd(8'h66, rd);
		check("reg kept", rd, 8'hF0);
		// Integer divider over every source code and both ends of the base range.
		for (int i = 0; i < 5; i++) begin
			tick();
			i_base_div = 5'(dq[i]);
			reg_wr(8'h66, 8'(i % 4) << 6);
			meas("divider span", 0, 3, 3 * dq[i] * dh[i]);
		end
		// DAC divides by 2.5, ADC by 1 doubled, from one reference.
		tick();
		i_base_div = 5'h04;
		i_dac_rate_divider = 4'h5;
		i_adc_double_rate = 1'b1;
		reg_wr(8'h66, 8'h00);
		meas("ref span", 1, 1, 4096);
		meas("dac span", 2, 1, 10240);
		meas("adc span", 3, 1, 2048);
		meas("word span", 4, 1, 2048);
		tick();
		i_split_word_clock = 1'b1;
		meas("split word span", 4, 1, 10240);
		meas("adc word span", 5, 1, 2048);
		check("split oe", o_aux_pin_one_oe, 1'b1);
		tick();
		i_split_word_clock = 1'b0;
		// Fractional loop within its specified ranges.
		for (int i = 0; i < 6; i++) begin
			tick();
			i_loop_en = 1'b1;
			i_whole_mult = 6'(lt[i][0]);
			i_frac_part = 14'(lt[i][1]);
			i_loop_gain = 5'(lt[i][2]);
			i_front_div = 4'(lt[i][3]);
			reg_wr(8'h66, 8'(lt[i][4]) << 4);
			meas("loop span", 0, lt[i][6], lt[i][5]);
		end
		check("loop active", o_loop_active, 1'b1);
		// Clock out, direct and through the loop.
		reg_wr(8'h66, 8'h20);
		for (int i = 0; i < 5; i++) begin
			tick();
			i_clock_out_en = 1'b1;
			i_clock_out_select = ct[i][0][0];
			i_loop_en = ct[i][1][0];
			i_out_div_a_sel = 2'(ct[i][2]);
			i_out_div_b = 5'(ct[i][3]);
			meas("clock out span", 5, 3, 3 * ct[i][4]);
			check("clock out oe", o_aux_pin_one_oe, 1'b1);
		end
		// Powered down, the loop still exports a clock taken from aux pin two.
		tick();
		i_codec_power_down = 1'b1;
		i_out_div_a_sel = 2'h2;
		i_out_div_b = 5'h04;
		reg_wr(8'h66, 8'h20);
		meas("export span", 5, 3, 48);
		c = 0;
		repeat (500) begin
			tick();
			if (o_master_tick !== 1'b0) c++;
		end
		check("ticks in power down", c, 0);
		stop_test();
	end

	// Watchdog, a margin past the longest expected run.
	initial begin
		#450000;
		failures++;
		stop_test();
	end
endmodule

`default_nettype wire
